// *** spm_pkg.sv ***
/*
 * Constants, types and carriers shared by the pin strap and GPIO mux.
 * Assumes one 250 MHz clock and a plain strobe-based register port.
 */
package spm_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int GPIO_W = 7;
	localparam int MIN_GPIO_W = 7;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_IRQ = 3;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_GPIO_DIR = 8'h00;
	localparam logic [7:0] REG_GPIO_OUT = 8'h04;
	localparam logic [7:0] REG_GPIO_IN = 8'h08;
	localparam logic [7:0] REG_ALT_SEL = 8'h0c;
	localparam logic [7:0] REG_PORT_RST = 8'h10;
	localparam logic [7:0] REG_STRAP = 8'h14;
	localparam logic [7:0] REG_EXP_IRQ = 8'h18;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] RST_GPIO_DIR = 7'h00;
	localparam logic [6:0] RST_GPIO_OUT = 7'h00;
	localparam logic [6:0] RST_ALT_SEL = 7'h00;
	localparam logic [1:0] RST_PORT_RST = 2'h0;

	// ----------------------------------------------------------------
	// Pin assignment of alternate functions
	// ----------------------------------------------------------------
	localparam int PIN_P2_RST = 0;
	localparam int PIN_P4_RST = 1;
	localparam int PIN_IRQ_LSB = 2;
	localparam logic [6:0] ALT_OUT_MASK = 7'h03;
	localparam logic [6:0] ALT_VALID_MASK = 7'h1f;

	// ----------------------------------------------------------------
	// Strap status field positions
	// ----------------------------------------------------------------
	localparam int STRAP_REFCLK_BIT = 0;
	localparam int STRAP_EE_LSB = 8;
	localparam int STRAP_SLV_LSB = 16;
	localparam int STRAP_VALID_BIT = 31;

	// ----------------------------------------------------------------
	// Fixed address bits, index is bus address bit minus one
	// ----------------------------------------------------------------
	localparam logic SLV_BIT4 = 1'b0;
	localparam logic SLV_BIT6 = 1'b1;
	localparam logic SLV_BIT7 = 1'b1;
	localparam logic MST_BIT5 = 1'b1;
	localparam logic MST_BIT6 = 1'b0;
	localparam logic MST_BIT7 = 1'b1;

	typedef enum logic {
		SPM_REF_100M,
		SPM_REF_125M
	} spm_refclk_e;

	typedef struct packed {
		spm_refclk_e refclk;
		logic [6:0] eeprom_addr;
		logic [6:0] slave_addr;
	} spm_strap_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} spm_bus_s;

endpackage

// *** spm_strap_capture.sv ***
/*
 * Captures the reference clock and SMBus address straps once, at the
 * first clock edge after the fundamental reset is released.
 * Assumes straps are steady around that edge and nrst is that reset.
 */
`timescale 1ns/10ps
`default_nettype none

module spm_strap_capture (
	input wire logic clk,
	input wire logic nrst,
	input wire logic refclk_freq_select,
	input wire logic [3:0] eeprom_addr_strap,
	input wire logic [3:0] slave_addr_strap,
	output var spm_pkg::spm_strap_s strap,
	output logic strap_valid
);

	typedef enum logic {
		SPM_CAP_WAIT,
		SPM_CAP_DONE
	} spm_cap_e;

	spm_cap_e state_q;

	// ----------------------------------------------------------------
	// Sampling
	// ----------------------------------------------------------------
	// Async reset loads constants only; the pins are read by the clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= SPM_CAP_WAIT;
			strap <= '0;
		end else begin
			unique case (state_q)
				SPM_CAP_WAIT: begin
					state_q <= SPM_CAP_DONE;
					strap.refclk <= refclk_freq_select ?
						spm_pkg::SPM_REF_125M : spm_pkg::SPM_REF_100M;
					strap.eeprom_addr <= {spm_pkg::MST_BIT7,
						spm_pkg::MST_BIT6, spm_pkg::MST_BIT5,
						eeprom_addr_strap};
					strap.slave_addr <= {spm_pkg::SLV_BIT7,
						spm_pkg::SLV_BIT6, slave_addr_strap[3],
						spm_pkg::SLV_BIT4, slave_addr_strap[2:0]};
				end
				SPM_CAP_DONE: begin
					state_q <= SPM_CAP_DONE;
				end
			endcase
		end
	end

	assign strap_valid = (state_q == SPM_CAP_DONE);

endmodule

`default_nettype wire

// *** spm_pin_cell.sv ***
/*
 * One general-purpose pin: chooses between the alternate function and
 * the plain direction and data settings, with registered pin drive.
 * Assumes the pad resolves the wire from pin_out and pin_oe_n.
 */
`timescale 1ns/10ps
`default_nettype none

module spm_pin_cell (
	input wire logic clk,
	input wire logic nrst,
	input wire logic alt_en,
	input wire logic alt_drive,
	input wire logic alt_val,
	input wire logic gp_dir,
	input wire logic gp_val,
	output logic pin_out,
	output logic pin_oe_n
);

	logic drive_d;
	logic val_d;

	always_comb begin
		drive_d = alt_en ? alt_drive : gp_dir;
		val_d = (alt_en && alt_drive) ? alt_val : gp_val;
	end

	// ----------------------------------------------------------------
	// Pad drive
	// ----------------------------------------------------------------
	// Pin comes out of reset as an undriven input
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_oe_n <= 1'b1;
			pin_out <= 1'b0;
		end else begin
			pin_oe_n <= !drive_d;
			pin_out <= val_d;
		end
	end

endmodule

`default_nettype wire

// *** spm_pin_mux_top.sv ***
/*
 * Pin strap decode and GPIO alternate-function mux of a serial switch,
 * with its software register port.
 * Assumes synchronous pin inputs, nrst is the fundamental reset, and
 * an outside config loader may push alternate selections.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Names ending in _n are asserted when the line is low.
// - All other signals except nrst are asserted when the line is high.
// - Refclk strap 0 selects 100 MHz, 1 selects 125 MHz.
// - Alternate pins 0 and 1 drive resets for ports two and four.
// - Alternate pins 2, 3, 4 take expander interrupts 0, 1, 2.
// - Pins 0 to 6 work as plain GPIO; pins 5, 6 lack alternates.
// - Four master straps give the configuration EEPROM address.
// - Slave interface answers only the address built from its straps.
// - Straps sampled at reset release, fixed bits filled in.
// - Alternate selection set by software, SMBus slave or EEPROM.
module spm_pin_mux_top #(
	parameter int GPIO_W = spm_pkg::GPIO_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire spm_pkg::spm_bus_s bus,
	output logic [31:0] rdata,
	input wire logic refclk_freq_select,
	input wire logic [3:0] eeprom_addr_strap,
	input wire logic [3:0] slave_addr_strap,
	input wire logic cfg_alt_wr,
	input wire logic [GPIO_W-1:0] cfg_alt_sel,
	input wire logic [6:0] smb_addr_in,
	input wire logic [GPIO_W-1:0] gpio_in,
	output logic [GPIO_W-1:0] gpio_out,
	output logic [GPIO_W-1:0] gpio_oe_n,
	output var spm_pkg::spm_refclk_e refclk_sel,
	output logic strap_valid,
	output logic [6:0] eeprom_smb_addr,
	output logic [6:0] slave_smb_addr,
	output logic slave_addr_hit,
	output logic [2:0] expander_irq
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (GPIO_W < spm_pkg::MIN_GPIO_W || GPIO_W > spm_pkg::DATA_W) begin
		$error("GPIO_W out of the range this mux serves");
	end

	localparam logic [GPIO_W-1:0] ALT_MASK =
		GPIO_W'(spm_pkg::ALT_VALID_MASK);
	localparam logic [GPIO_W-1:0] OUT_MASK =
		GPIO_W'(spm_pkg::ALT_OUT_MASK);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	function automatic logic [31:0] pad(input logic [GPIO_W-1:0] v);
		pad = 32'(v);
	endfunction

	logic [GPIO_W-1:0] dir_q;
	logic [GPIO_W-1:0] out_q;
	logic [GPIO_W-1:0] alt_q;
	logic [GPIO_W-1:0] in_q;
	logic [1:0] prst_q;
	logic [2:0] irq_q;
	logic hit_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_val;
	logic [GPIO_W-1:0] alt_val;
	logic port_two_reset_out_n;
	logic port_four_reset_out_n;
	logic [2:0] expander_irq_n;
	logic sw_alt_wr;
	spm_pkg::spm_strap_s strap;

	// ----------------------------------------------------------------
	// Straps
	// ----------------------------------------------------------------
	spm_strap_capture u_strap (
		.clk(clk),
		.nrst(nrst),
		.refclk_freq_select(refclk_freq_select),
		.eeprom_addr_strap(eeprom_addr_strap),
		.slave_addr_strap(slave_addr_strap),
		.strap(strap),
		.strap_valid(strap_valid)
	);

	assign refclk_sel = strap.refclk;
	assign eeprom_smb_addr = strap.eeprom_addr;
	assign slave_smb_addr = strap.slave_addr;

	// Compare registered so the SMBus slave sees a clean level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= strap_valid && (smb_addr_in == strap.slave_addr);
		end
	end

	assign slave_addr_hit = hit_q;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	assign sw_alt_wr = bus.wr && hit(bus.addr, spm_pkg::REG_ALT_SEL);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_q <= GPIO_W'(spm_pkg::RST_GPIO_DIR);
			out_q <= GPIO_W'(spm_pkg::RST_GPIO_OUT);
		end else if (bus.wr) begin
			if (hit(bus.addr, spm_pkg::REG_GPIO_DIR)) begin
				dir_q <= bus.wdata[GPIO_W-1:0];
			end
			if (hit(bus.addr, spm_pkg::REG_GPIO_OUT)) begin
				out_q <= bus.wdata[GPIO_W-1:0];
			end
		end
	end

	// Software write wins over a config load in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alt_q <= GPIO_W'(spm_pkg::RST_ALT_SEL);
		end else if (sw_alt_wr) begin
			alt_q <= bus.wdata[GPIO_W-1:0] & ALT_MASK;
		end else if (cfg_alt_wr) begin
			alt_q <= cfg_alt_sel & ALT_MASK;
		end
	end

	// Bit set means the downstream port is held in reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prst_q <= spm_pkg::RST_PORT_RST;
		end else if (bus.wr && hit(bus.addr, spm_pkg::REG_PORT_RST)) begin
			prst_q <= bus.wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = '0;
		case (bus.addr)
			spm_pkg::REG_GPIO_DIR: rd_val = pad(dir_q);
			spm_pkg::REG_GPIO_OUT: rd_val = pad(out_q);
			spm_pkg::REG_GPIO_IN: rd_val = pad(in_q);
			spm_pkg::REG_ALT_SEL: rd_val = pad(alt_q);
			spm_pkg::REG_PORT_RST: rd_val = {30'h0, prst_q};
			spm_pkg::REG_STRAP: begin
				rd_val[spm_pkg::STRAP_REFCLK_BIT] = strap.refclk;
				rd_val[spm_pkg::STRAP_EE_LSB +: 7] = strap.eeprom_addr;
				rd_val[spm_pkg::STRAP_SLV_LSB +: 7] = strap.slave_addr;
				rd_val[spm_pkg::STRAP_VALID_BIT] = strap_valid;
			end
			spm_pkg::REG_EXP_IRQ: rd_val = {29'h0, irq_q};
			default: rd_val = '0;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= bus.rd ? rd_val : '0;
		end
	end

	assign rdata = rdata_q;

	// ----------------------------------------------------------------
	// Alternate functions
	// ----------------------------------------------------------------
	// Reset outputs are low-true on the wire
	assign port_two_reset_out_n = !prst_q[0];
	assign port_four_reset_out_n = !prst_q[1];

	always_comb begin
		alt_val = '0;
		alt_val[spm_pkg::PIN_P2_RST] = port_two_reset_out_n;
		alt_val[spm_pkg::PIN_P4_RST] = port_four_reset_out_n;
	end

	// Unselected interrupt pins read as idle, never asserted
	assign expander_irq_n = gpio_in[spm_pkg::PIN_IRQ_LSB +: 3] |
		~alt_q[spm_pkg::PIN_IRQ_LSB +: 3];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_q <= '0;
			irq_q <= '0;
		end else begin
			in_q <= gpio_in;
			irq_q <= ~expander_irq_n;
		end
	end

	assign expander_irq = irq_q;

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------
	for (genvar i = 0; i < GPIO_W; i++) begin : g_pin
		spm_pin_cell u_cell (
			.clk(clk),
			.nrst(nrst),
			.alt_en(alt_q[i]),
			.alt_drive(OUT_MASK[i]),
			.alt_val(alt_val[i]),
			.gp_dir(dir_q[i]),
			.gp_val(out_q[i]),
			.pin_out(gpio_out[i]),
			.pin_oe_n(gpio_oe_n[i])
		);
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	idle_pins_input_a: assert property (
		(dir_q == '0 && alt_q == '0) |=> (gpio_oe_n == '1))
		else $error("idle pin driven");

	port_two_rst_a: assert property (
		alt_q[0] |=> (!gpio_oe_n[0] && gpio_out[0] == !$past(prst_q[0])))
		else $error("port two reset pin wrong");

	port_four_rst_a: assert property (
		alt_q[1] |=> (!gpio_oe_n[1] && gpio_out[1] == !$past(prst_q[1])))
		else $error("port four reset pin wrong");

	expander_irq_a: assert property (
		1'b1 |=> (expander_irq == ($past(alt_q[4:2]) &
			~$past(gpio_in[4:2]))))
		else $error("expander interrupt mismatch");

	irq_pin_input_a: assert property (
		alt_q[2] && alt_q[3] && alt_q[4] |=> (gpio_oe_n[4:2] == 3'h7))
		else $error("interrupt pin driven");

	plain_gpio_a: assert property (
		(!alt_q[5] && dir_q[5]) |=>
			(!gpio_oe_n[5] && gpio_out[5] == $past(out_q[5])))
		else $error("plain gpio pin wrong");

	no_alt_high_a: assert property (
		alt_q[6:5] == 2'h0)
		else $error("alternate set on plain pin");

	refclk_decode_a: assert property (
		$rose(strap_valid) |->
			((refclk_sel == spm_pkg::SPM_REF_125M) ==
			$past(refclk_freq_select)))
		else $error("refclk strap decode wrong");

	strap_hold_a: assert property (
		strap_valid |=> (strap_valid && $stable(eeprom_smb_addr) &&
			$stable(slave_smb_addr) && $stable(refclk_sel)))
		else $error("strap changed after capture");

	fixed_bits_a: assert property (
		strap_valid |-> (eeprom_smb_addr[6:4] == 3'h5 &&
			slave_smb_addr[6:5] == 2'h3 && !slave_smb_addr[3]))
		else $error("fixed address bits wrong");

	slave_match_a: assert property (
		slave_addr_hit |-> ($past(smb_addr_in) == $past(slave_smb_addr)))
		else $error("slave hit on foreign address");

	cfg_load_a: assert property (
		(cfg_alt_wr && !sw_alt_wr) |=>
			(alt_q == ($past(cfg_alt_sel) & ALT_MASK)))
		else $error("config load of alternate lost");

	read_idle_a: assert property (
		!bus.rd |=> (rdata == '0))
		else $error("read data outside read slot");

	eeprom_addr_a: assert property (
		$rose(strap_valid) |->
			(eeprom_smb_addr[3:0] == $past(eeprom_addr_strap)))
		else $error("eeprom address strap wrong");

	slave_addr_a: assert property (
		$rose(strap_valid) |->
			({slave_smb_addr[4], slave_smb_addr[2:0]} ==
			$past(slave_addr_strap)))
		else $error("slave address strap wrong");

	strap_read_a: assert property (
		(bus.rd && bus.addr == spm_pkg::REG_STRAP) |=>
			(rdata[31] == $past(strap_valid)))
		else $error("strap valid read wrong");

	port_rst_c: cover property (alt_q[0] && prst_q[0] ##1 !gpio_out[0]);
	irq_seen_c: cover property (expander_irq != 3'h0);
	cfg_load_c: cover property (cfg_alt_wr && !sw_alt_wr);
	slave_hit_c: cover property (slave_addr_hit);
	strap_cap_c: cover property ($rose(strap_valid));

endmodule

`default_nettype wire

// *** spm_board_model.sv ***
/*
 * Board side of the pin mux: pull-ups, expander interrupt lines, a
 * bench-controlled external driver and the two slot reset inputs.
 * Assumes a pin is driven by the design while its gpio_oe_n is low.
 */
`timescale 1ns/10ps
`default_nettype none

module spm_board_model (
	input wire logic [6:0] gpio_out,
	input wire logic [6:0] gpio_oe_n,
	input wire logic [2:0] irq_req,
	input wire logic [6:0] ext_oe,
	input wire logic [6:0] ext_val,
	output logic [6:0] gpio_in,
	output logic port_two_reset_out_n,
	output logic port_four_reset_out_n
);
	logic [6:0] pull_n;

	// Expander lines are open drain, low while an event is pending
	assign pull_n = {2'b11, ~irq_req, 2'b11};

	// Undriven lines float to their pull-up level
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (!gpio_oe_n[i])
				gpio_in[i] = gpio_out[i];
			else if (ext_oe[i])
				gpio_in[i] = ext_val[i];
			else
				gpio_in[i] = pull_n[i];
		end
	end

	assign port_two_reset_out_n = gpio_in[0];
	assign port_four_reset_out_n = gpio_in[1];
endmodule

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench for the pin strap and GPIO mux.
 * Assumes one 250 MHz clock and the board model on the far side.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic clk, nrst, rc, cfg_alt_wr, hit, strap_valid;
	logic port_two_reset_out_n, port_four_reset_out_n;
	spm_pkg::spm_bus_s bus;
	spm_pkg::spm_refclk_e refclk_sel;
	logic [31:0] rdata, d;
	logic [3:0] ee, sl;
	logic [6:0] alt, smb, gin, gout, oe_n, ext_oe, ext_val, ee_a, sl_a;
	logic [2:0] irq, irq_req;
	int errors, n_checks;

	spm_pin_mux_top uut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
		.refclk_freq_select(rc), .eeprom_addr_strap(ee),
		.slave_addr_strap(sl), .cfg_alt_wr(cfg_alt_wr),
		.cfg_alt_sel(alt), .smb_addr_in(smb), .gpio_in(gin),
		.gpio_out(gout), .gpio_oe_n(oe_n), .refclk_sel(refclk_sel),
		.strap_valid(strap_valid), .eeprom_smb_addr(ee_a),
		.slave_smb_addr(sl_a), .slave_addr_hit(hit), .expander_irq(irq));
	spm_board_model board (.gpio_out(gout), .gpio_oe_n(oe_n),
		.irq_req(irq_req), .ext_oe(ext_oe), .ext_val(ext_val),
		.gpio_in(gin), .port_two_reset_out_n(port_two_reset_out_n),
		.port_four_reset_out_n(port_four_reset_out_n));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", name, e, g);
			errors++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_straps(input logic r, input logic [3:0] e,
		input logic [3:0] s);
		logic [6:0] xe, xs;
		xe = {3'b101, e};
		xs = {2'b11, s[3], 1'b0, s[2:0]};
		@(posedge clk);
		nrst <= 1'b0;
		rc <= r;
		ee <= e;
		sl <= s;
		repeat (6) @(posedge clk);
		#1 chk("oe_n", 7'h7f, oe_n);
		@(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rc <= ~r;
		ee <= ~e;
		sl <= ~s;
		@(posedge clk);
		#1 chk("valid", 1, strap_valid);
		chk("refclk", r ? spm_pkg::SPM_REF_125M : spm_pkg::SPM_REF_100M,
			refclk_sel);
		chk("ee_addr", xe, ee_a);
		chk("slv_addr", xs, sl_a);
		rd(spm_pkg::REG_STRAP);
		chk("strap", {1'b1, 8'h00, xs, 1'b0, xe, 7'h00, r}, d);
		@(posedge clk);
		smb <= xs;
		repeat (2) @(posedge clk);
		#1 chk("hit", 1, hit);
		@(posedge clk);
		smb <= xs ^ 7'h08;
		repeat (2) @(posedge clk);
		#1 chk("miss", 0, hit);
		$display("t_straps done");
	endtask

	task automatic t_gpio;
		wr(spm_pkg::REG_GPIO_DIR, 32'h7f);
		wr(spm_pkg::REG_GPIO_OUT, 32'h55);
		@(posedge clk);
		#1 chk("oe_n", 0, oe_n);
		chk("out", 32'h55, gout);
		wr(spm_pkg::REG_GPIO_DIR, 32'h0);
		ext_oe <= 7'h7f;
		ext_val <= 7'h2a;
		repeat (3) @(posedge clk);
		rd(spm_pkg::REG_GPIO_IN);
		chk("gpio_in", 32'h2a, d);
		@(posedge clk);
		ext_oe <= 7'h00;
		$display("t_gpio done");
	endtask

	task automatic t_alt;
		wr(spm_pkg::REG_ALT_SEL, 32'h7f);
		rd(spm_pkg::REG_ALT_SEL);
		chk("alt", 32'h1f, d);
		wr(spm_pkg::REG_PORT_RST, 32'h1);
		@(posedge clk);
		#1 chk("p2_rst_n", 0, port_two_reset_out_n);
		chk("p4_rst_n", 1, port_four_reset_out_n);
		chk("oe_n", 7'h7c, oe_n);
		wr(spm_pkg::REG_PORT_RST, 32'h2);
		@(posedge clk);
		#1 chk("p2_rst_n", 1, port_two_reset_out_n);
		chk("p4_rst_n", 0, port_four_reset_out_n);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			irq_req <= 3'(1 << i);
			repeat (2) @(posedge clk);
			#1 chk("irq", 1 << i, irq);
			rd(spm_pkg::REG_EXP_IRQ);
			chk("irq_reg", 1 << i, d);
		end
		wr(spm_pkg::REG_ALT_SEL, 32'h0);
		irq_req <= 3'h7;
		repeat (2) @(posedge clk);
		#1 chk("irq_off", 0, irq);
		chk("oe_n", 7'h7f, oe_n);
		@(posedge clk);
		irq_req <= 3'h0;
		$display("t_alt done");
	endtask

	task automatic t_cfg;
		@(posedge clk);
		alt <= 7'h04;
		cfg_alt_wr <= 1'b1;
		@(posedge clk);
		cfg_alt_wr <= 1'b0;
		rd(spm_pkg::REG_ALT_SEL);
		chk("cfg_alt", 32'h04, d);
		@(posedge clk);
		bus.addr <= spm_pkg::REG_ALT_SEL;
		bus.wdata <= 32'h02;
		bus.wr <= 1'b1;
		alt <= 7'h08;
		cfg_alt_wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		cfg_alt_wr <= 1'b0;
		rd(spm_pkg::REG_ALT_SEL);
		chk("sw_wins", 32'h02, d);
		rd(8'h1c);
		chk("unmapped", 0, d);
		$display("t_cfg done");
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		errors++;
		$display("ERROR watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		nrst = 1'b0;
		bus = '0;
		{rc, ee, sl, cfg_alt_wr, alt, smb} = '0;
		{irq_req, ext_oe, ext_val} = '0;
		errors = 0;
		n_checks = 0;
		t_straps(1'b1, 4'ha, 4'h5);
		t_straps(1'b0, 4'h3, 4'ha);
		t_gpio();
		t_alt();
		t_cfg();
		stop_test();
	end
endmodule

`default_nettype wire
